// ### src/port_direction_pkg.sv
// Operation
// RULE1: Every pin of both ports has its own independent direction bit.
// RULE2: Direction bit 0 enables the output buffer; 1 disables it for input.
// RULE3: Reset loads both direction registers with all ones, all pins input.
// RULE4: Direction registers accept whole-byte writes and single-bit set or clear.
// RULE5: Software clears direction and latch bits before timer output use.
// RULE6: Software sets direction bits to one for timer input use.
// RULE7: Port one direction register uses all eight bits, zero to seven.
// RULE8: Port three direction holds bits zero to three; bits four to seven read one.
// RULE9: Output-mode pins drive the latch; input-mode pins stay undriven.
package port_direction_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int PORT_ONE_PINS = 8;
  localparam int PORT_THREE_PINS = 4;
  localparam int BIT_IDX_W = 3;

  localparam logic [15:0] PORT_ONE_DIRECTION_ADDR = 16'hFF21;
  localparam logic [15:0] PORT_THREE_DIRECTION_ADDR = 16'hFF23;
  localparam logic [15:0] PORT_ONE_LATCH_ADDR = 16'hFF01;
  localparam logic [15:0] PORT_THREE_LATCH_ADDR = 16'hFF03;
  localparam logic [15:0] PORT_ONE_LEVEL_ADDR = 16'hFF11;
  localparam logic [15:0] PORT_THREE_LEVEL_ADDR = 16'hFF13;
  localparam logic [15:0] BIT_OP_ADDR = 16'hFF30;

  localparam logic [7:0] DIRECTION_RESET = 8'hFF;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] LEVEL_RESET = 8'h00;
  localparam logic [7:0] READ_IDLE = 8'h00;
  localparam logic [3:0] PORT_THREE_FIXED_HIGH = 4'hF;

  localparam int BIT_OP_VALUE_POS = 7;
  localparam int BIT_OP_TARGET_LSB = 4;
  localparam int BIT_OP_IDX_LSB = 0;

  localparam logic [1:0] TARGET_ONE_DIRECTION = 2'h0;
  localparam logic [1:0] TARGET_THREE_DIRECTION = 2'h1;
  localparam logic [1:0] TARGET_ONE_LATCH = 2'h2;
  localparam logic [1:0] TARGET_THREE_LATCH = 2'h3;

  localparam logic DIR_OUTPUT = 1'b0;
  localparam logic DIR_INPUT = 1'b1;
endpackage : port_direction_pkg

// ### src/port_slice_if.sv
`timescale 1ns/1ps
`default_nettype none
interface port_slice_if #(parameter int WIDTH = 8);
  logic [7:0] wr_data;
  logic dir_we;
  logic latch_we;
  logic dir_bit_we;
  logic latch_bit_we;
  logic [2:0] bit_idx;
  logic bit_val;
  logic [WIDTH-1:0] direction;
  logic [WIDTH-1:0] latch;

  modport ctl (output wr_data, dir_we, latch_we, dir_bit_we, latch_bit_we, bit_idx, bit_val,
               input direction, latch);
  modport slice (input wr_data, dir_we, latch_we, dir_bit_we, latch_bit_we, bit_idx, bit_val,
                 output direction, latch);
endinterface : port_slice_if
`default_nettype wire

// ### src/port_slice.sv
`timescale 1ns/1ps
`default_nettype none
module port_slice
  import port_direction_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  port_slice_if.slice bus
);
  if (WIDTH < 1 || WIDTH > 8)
  begin : g_bad_width
    $error("port_slice WIDTH must be 1 to 8");
  end

  logic [WIDTH-1:0] next_direction;
  logic [WIDTH-1:0] next_latch;

  // A bit operation wins over a byte write; the strobes never coincide anyway
  always_comb
  begin
    next_direction = bus.direction;
    next_latch = bus.latch;
    if (bus.dir_we)
      next_direction = bus.wr_data[WIDTH-1:0]; // RULE4
    if (bus.latch_we)
      next_latch = bus.wr_data[WIDTH-1:0];
    for (int i = 0; i < WIDTH; i++)
    begin
      if (bus.dir_bit_we && bus.bit_idx == 3'(i))
        next_direction[i] = bus.bit_val; // RULE1 RULE4
      if (bus.latch_bit_we && bus.bit_idx == 3'(i))
        next_latch[i] = bus.bit_val;
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bus.direction <= DIRECTION_RESET[WIDTH-1:0]; // RULE3
      bus.latch <= LATCH_RESET[WIDTH-1:0];
    end
    else if (ce)
    begin
      bus.direction <= next_direction;
      bus.latch <= next_latch;
    end
  end
endmodule : port_slice
`default_nettype wire

// ### src/port_direction_control.sv
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module port_direction_control
  import port_direction_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic [15:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  input wire logic [7:0] port_one_pin_in,
  output logic [7:0] port_one_pin_out,
  output logic [7:0] port_one_pin_oe_n,
  input wire logic [3:0] port_three_pin_in,
  output logic [3:0] port_three_pin_out,
  output logic [3:0] port_three_pin_oe_n,
  output logic timer_a_input,
  output logic timer_b_input
);
  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  port_slice_if #(.WIDTH(PORT_ONE_PINS)) one_if ();
  port_slice_if #(.WIDTH(PORT_THREE_PINS)) three_if ();

  wire wr_act = ce && wr_en;
  wire hit_one_dir = (addr == PORT_ONE_DIRECTION_ADDR);
  wire hit_three_dir = (addr == PORT_THREE_DIRECTION_ADDR);
  wire hit_one_latch = (addr == PORT_ONE_LATCH_ADDR);
  wire hit_three_latch = (addr == PORT_THREE_LATCH_ADDR);
  wire hit_one_level = (addr == PORT_ONE_LEVEL_ADDR);
  wire hit_three_level = (addr == PORT_THREE_LEVEL_ADDR);
  wire hit_bit_op = (addr == BIT_OP_ADDR);

  wire [1:0] bit_target = wr_data[BIT_OP_TARGET_LSB +: 2];
  wire [2:0] bit_idx = wr_data[BIT_OP_IDX_LSB +: BIT_IDX_W];
  wire bit_val = wr_data[BIT_OP_VALUE_POS];
  wire bit_act = wr_act && hit_bit_op;

  assign one_if.wr_data = wr_data;
  assign one_if.dir_we = wr_act && hit_one_dir; // RULE7
  assign one_if.latch_we = wr_act && hit_one_latch;
  assign one_if.dir_bit_we = bit_act && bit_target == TARGET_ONE_DIRECTION;
  assign one_if.latch_bit_we = bit_act && bit_target == TARGET_ONE_LATCH;
  assign one_if.bit_idx = bit_idx;
  assign one_if.bit_val = bit_val;

  // Upper four data bits of a port three write are dropped inside the slice
  assign three_if.wr_data = wr_data;
  assign three_if.dir_we = wr_act && hit_three_dir; // RULE8
  assign three_if.latch_we = wr_act && hit_three_latch;
  assign three_if.dir_bit_we = bit_act && bit_target == TARGET_THREE_DIRECTION;
  assign three_if.latch_bit_we = bit_act && bit_target == TARGET_THREE_LATCH;
  assign three_if.bit_idx = bit_idx;
  assign three_if.bit_val = bit_val;

  port_slice #(.WIDTH(PORT_ONE_PINS)) u_port_one (
    .mclk(mclk),
    .reset_n(reset_n),
    .ce(ce),
    .bus(one_if.slice)
  );

  port_slice #(.WIDTH(PORT_THREE_PINS)) u_port_three (
    .mclk(mclk),
    .reset_n(reset_n),
    .ce(ce),
    .bus(three_if.slice)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pins

  // Enable is the direction bit itself, so a direction change reaches the pin
  // in the same edge and no glitch cycle drives a stale level
  assign port_one_pin_oe_n = one_if.direction; // RULE2 RULE9
  assign port_one_pin_out = one_if.latch; // RULE9
  assign port_three_pin_oe_n = three_if.direction; // RULE2 RULE9
  assign port_three_pin_out = three_if.latch; // RULE9

  logic [7:0] one_level;
  logic [3:0] three_level;

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      one_level <= LEVEL_RESET;
      three_level <= LEVEL_RESET[3:0];
    end
    else if (ce)
    begin
      one_level <= port_one_pin_in;
      three_level <= port_three_pin_in;
    end
  end

  // Timer inputs see the registered pin level whatever the direction
  assign timer_a_input = one_level[7];
  assign timer_b_input = three_level[3];

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  wire [7:0] three_dir_view = {PORT_THREE_FIXED_HIGH, three_if.direction}; // RULE8
  wire [7:0] read_mux =
    hit_one_dir ? one_if.direction :
    hit_three_dir ? three_dir_view :
    hit_one_latch ? one_if.latch :
    hit_three_latch ? {4'h0, three_if.latch} :
    hit_one_level ? one_level :
    hit_three_level ? {4'h0, three_level} :
    READ_IDLE;

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      rd_data <= READ_IDLE;
    else if (ce)
      rd_data <= rd_en ? read_mux : READ_IDLE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  wire [7:0] bit_mask = 8'(8'h01 << bit_idx);

  chk_reset_all_input: assert property ( // RULE3
    @(posedge mclk) disable iff (!reset_n)
    !$past(reset_n) |-> (port_one_pin_oe_n == 8'hFF && port_three_pin_oe_n == 4'hF))
    else $error("pins not all input after reset");

  chk_byte_dir_write: assert property ( // RULE4
    @(posedge mclk) disable iff (!reset_n)
    (ce && wr_en && addr == PORT_ONE_DIRECTION_ADDR) |=> port_one_pin_oe_n == $past(wr_data))
    else $error("port one direction byte write lost");

  chk_bit_op_target: assert property ( // RULE1
    @(posedge mclk) disable iff (!reset_n)
    (bit_act && bit_target == TARGET_ONE_DIRECTION)
      |=> ((port_one_pin_oe_n ^ $past(port_one_pin_oe_n)) & ~$past(bit_mask)) == 8'h00
          && (port_one_pin_oe_n & $past(bit_mask)) == ($past(bit_val) ? $past(bit_mask) : 8'h00))
    else $error("bit operation touched wrong direction bits");

  chk_three_fixed_high: assert property ( // RULE8
    @(posedge mclk) disable iff (!reset_n)
    (ce && rd_en && addr == PORT_THREE_DIRECTION_ADDR)
      |=> rd_data == {4'hF, $past(port_three_pin_oe_n)}
    ##1 (rd_data == READ_IDLE || $past(ce && rd_en) || !$past(ce)))
    else $error("port three direction read wrong");

  chk_one_full_width: assert property ( // RULE7
    @(posedge mclk) disable iff (!reset_n)
    (ce && rd_en && addr == PORT_ONE_DIRECTION_ADDR) |=> rd_data == $past(port_one_pin_oe_n))
    else $error("port one direction read wrong");

  chk_output_mode_drive: assert property ( // RULE2
    @(posedge mclk) disable iff (!reset_n)
    (ce && wr_en && addr == PORT_THREE_DIRECTION_ADDR && wr_data[0] == DIR_OUTPUT)
      |=> !port_three_pin_oe_n[0] [*1] ##0 $stable(port_three_pin_out))
    else $error("port three pin zero not driving");

  chk_latch_to_pin: assert property ( // RULE9
    @(posedge mclk) disable iff (!reset_n)
    (ce && wr_en && addr == PORT_ONE_LATCH_ADDR) |=> port_one_pin_out == $past(wr_data))
    else $error("latch write not on pin");

  chk_freeze_low_ce: assert property (
    @(posedge mclk) disable iff (!reset_n)
    !ce |=> $stable(port_one_pin_oe_n) && $stable(port_one_pin_out) && $stable(rd_data))
    else $error("state changed with clock enable low");

  cov_timer_output_setup: cover property (
    @(posedge mclk) disable iff (!reset_n)
    !port_one_pin_oe_n[7] && !port_one_pin_out[7] && !port_three_pin_oe_n[3]);

  cov_bit_clear: cover property (
    @(posedge mclk) disable iff (!reset_n)
    bit_act && !bit_val ##1 rd_en);

  cov_fixed_read: cover property (
    @(posedge mclk) disable iff (!reset_n)
    ce && rd_en && hit_three_dir);
endmodule : port_direction_control
`default_nettype wire

// ### testbench/pin_partner.sv
`timescale 1ns/1ps
`default_nettype none
module pin_partner
#(
  parameter int WIDTH = 8
)
(
  input wire logic [WIDTH-1:0] pin_out,
  input wire logic [WIDTH-1:0] pin_oe_n,
  input wire logic [WIDTH-1:0] ext_level,
  output logic [WIDTH-1:0] pin_in
);
  // The outside source steps back wherever the device drives, so no contention
  assign pin_in = (pin_out & ~pin_oe_n) | (ext_level & pin_oe_n);
endmodule : pin_partner
`default_nettype wire

// ### testbench/port_direction_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module port_direction_control_tb;
  import port_direction_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic ce = 1'b1;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wr_data = 8'h00;
  logic [7:0] ext1 = 8'h5A;
  logic [3:0] ext3 = 4'h6;
  logic [7:0] rd_data, p1_in, p1_out, p1_oe_n;
  logic [3:0] p3_in, p3_out, p3_oe_n;
  logic ta, tb;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;

  always #10 mclk = ~mclk;

  port_direction_control DUT (.mclk(mclk), .reset_n(reset_n), .ce(ce), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .port_one_pin_in(p1_in), .port_one_pin_out(p1_out),
    .port_one_pin_oe_n(p1_oe_n), .port_three_pin_in(p3_in), .port_three_pin_out(p3_out),
    .port_three_pin_oe_n(p3_oe_n), .timer_a_input(ta), .timer_b_input(tb));
  pin_partner #(.WIDTH(8)) pins_one (.pin_out(p1_out), .pin_oe_n(p1_oe_n), .ext_level(ext1), .pin_in(p1_in));
  pin_partner #(.WIDTH(4)) pins_three (.pin_out(p3_out), .pin_oe_n(p3_oe_n), .ext_level(ext3), .pin_in(p3_in));

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge mclk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1;
    check(rd_data, exp);
  endtask : rd

  // Single-bit set or clear through the bit operation register
  task automatic bit_op(input logic v, input logic [1:0] t, input logic [2:0] i);
    wr(BIT_OP_ADDR, {v, 1'b0, t, 1'b0, i});
  endtask : bit_op

  task automatic stop_test;
    if (mismatches == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test

  //////////////////////////////////////////////////////////////////////////////
  // Whole run needs under a hundred cycles; the ceiling leaves ample margin
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles > 3000)
    begin
      mismatches++;
      stop_test();
    end
  end

  initial
  begin
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    #1;
    check(p1_oe_n, 8'hFF);
    check({4'h0, p3_oe_n}, 8'h0F);
    rd(PORT_ONE_DIRECTION_ADDR, 8'hFF);
    rd(PORT_THREE_DIRECTION_ADDR, 8'hFF);
    rd(PORT_ONE_LEVEL_ADDR, 8'h5A);
    rd(PORT_THREE_LEVEL_ADDR, 8'h06);
    wr(PORT_ONE_LATCH_ADDR, 8'h3C);
    wr(PORT_ONE_DIRECTION_ADDR, 8'hA5);
    check(p1_oe_n, 8'hA5);
    rd(PORT_ONE_DIRECTION_ADDR, 8'hA5);
    rd(PORT_ONE_LEVEL_ADDR, (8'h3C & ~8'hA5) | (8'h5A & 8'hA5));
    wr(PORT_THREE_DIRECTION_ADDR, 8'h00);
    check({4'h0, p3_oe_n}, 8'h00);
    rd(PORT_THREE_DIRECTION_ADDR, 8'hF0);
    wr(PORT_ONE_DIRECTION_ADDR, 8'hFF);
    for (int i = 0; i < 8; i++)
    begin
      bit_op(1'b0, 2'h0, i[2:0]);
      check(p1_oe_n, 8'hFF << (i + 1));
    end
    // Index beyond the four-pin port must leave it alone
    bit_op(1'b1, 2'h1, 3'h4);
    rd(PORT_THREE_DIRECTION_ADDR, 8'hF0);
    bit_op(1'b1, 2'h1, 3'h2);
    rd(PORT_THREE_DIRECTION_ADDR, 8'hF4);
    bit_op(1'b1, 2'h2, 3'h7);
    check(p1_out, 8'hBC);
    rd(PORT_ONE_LATCH_ADDR, 8'hBC);
    bit_op(1'b1, 2'h3, 3'h3);
    check({4'h0, p3_out}, 8'h08);
    rd(PORT_THREE_LATCH_ADDR, 8'h08);
    // Timer pins as outputs: latch and direction cleared, outside level opposes
    bit_op(1'b0, 2'h2, 3'h7);
    bit_op(1'b0, 2'h3, 3'h3);
    bit_op(1'b0, 2'h1, 3'h3);
    ext1 <= 8'hDA;
    ext3 <= 4'hE;
    repeat (3) @(posedge mclk);
    #1;
    check({6'h00, ta, tb}, 8'h00);
    // Timer pins as inputs: the outside level reaches the timers
    bit_op(1'b1, 2'h0, 3'h7);
    bit_op(1'b1, 2'h1, 3'h3);
    repeat (3) @(posedge mclk);
    #1;
    check({6'h00, ta, tb}, 8'h03);
    check({4'h0, p3_oe_n}, 8'h0C);
    @(posedge mclk);
    ce <= 1'b0;
    wr(PORT_ONE_DIRECTION_ADDR, 8'h00);
    @(posedge mclk);
    ce <= 1'b1;
    #1;
    check(p1_oe_n, 8'h80);
    rd(16'hFF40, 8'h00);
    // A second reset in mid-run must undo changed direction and latch state
    @(posedge mclk);
    reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    #1;
    check(p1_oe_n, 8'hFF);
    check(p1_out, 8'h00);
    rd(PORT_THREE_DIRECTION_ADDR, 8'hFF);
    stop_test();
  end
endmodule : port_direction_control_tb
`default_nettype wire
